/* File: design/drive_serial_comm_config.sv */
// Register access over APB and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

// How it works
// - Station number 1..32 is settable; only frames with that number are accepted.
// - Framing bit: 0 selects RTU, 1 selects ASCII; both ends agree.
// - Baud code 0 is 4800, 1 is 9600, 3 is 38400 bit/s.
// - Stop bits, parity and data width are set before exchanging frames.
// - Link timeout is settable 0.0 to 25.5 s in 0.1 s steps.
// - Action 0 on timeout: decelerate with time 1, show timeout indication.
// - Timeout time of zero disables supervision.
// - Action 1 coasts, 2 uses decel time 2, 3 keeps running; all indicate.
// - Response starts 5 to 65 ms after the accepted request.
module drive_serial_comm_config #(
  parameter int unsigned TENTH_CYC = serial_cfg_pkg::TENTH_CYCLES,
  parameter int unsigned MS_CYC    = serial_cfg_pkg::MS_CYCLES
) (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [7:0]                paddr,
  input  wire logic [31:0]               pwdata,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      frame_valid,
  input  wire logic [7:0]                frame_station,
  output logic                           frame_accept,
  output logic                           resp_start,
  output serial_cfg_pkg::char_fmt_t      char_fmt,
  output logic      [15:0]               baud_div,
  output logic                           link_timeout_indication,
  output serial_cfg_pkg::stop_cmd_t      stop_cmd,
  output logic                           irq
);
  import serial_cfg_pkg::*;

  state_t s_reg;
  state_t s_next;
  logic   wr;
  logic   rd;
  logic   mapped;
  logic   hit;
  logic   expire;
  logic   wt_done;
  logic [1:0] ev;

  ////////////////////////////////////////////////////////////////////////////
  // Bus decode, always ready

  assign wr      = psel & penable & pwrite;
  assign rd      = psel & ~pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == ADDR_STATION) | (paddr == ADDR_FORMAT) | (paddr == ADDR_TIMEOUT) |
                   (paddr == ADDR_TXWAIT) | (paddr == ADDR_STATUS) | (paddr == ADDR_MASK) |
                   (paddr == ADDR_STATE);
  assign pslverr = psel & penable & ~mapped;

  always_comb begin
    prdata = 32'h0;
    if (rd) begin
      unique case (paddr)
        ADDR_STATION: prdata = {26'h0, s_reg.station};
        ADDR_FORMAT:  prdata = {25'h0, s_reg.fmt};
        ADDR_TIMEOUT: prdata = {22'h0, s_reg.to_action, s_reg.to_time};
        ADDR_TXWAIT:  prdata = {25'h0, s_reg.wait_ms};
        ADDR_STATUS:  prdata = {30'h0, s_reg.status};
        ADDR_MASK:    prdata = {30'h0, s_reg.mask};
        ADDR_STATE:   prdata = {30'h0, s_reg.wstate == W_BUSY, s_reg.timed_out};
        default:      prdata = 32'h0;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Frame filter and timers

  assign hit     = frame_valid & (frame_station == {2'h0, s_reg.station});
  assign expire  = (s_reg.to_time != 8'h0) & ~s_reg.timed_out & ~hit &
                   (s_reg.to_sub == TENTH_CYC - 1) &
                   (s_reg.to_tenth == s_reg.to_time - 8'h1);
  assign wt_done = (s_reg.wstate == W_BUSY) & (s_reg.wt_sub == MS_CYC - 1) &
                   (s_reg.wt_ms == s_reg.wait_ms - 7'h1);
  assign ev      = {hit, expire};

  always_comb begin
    s_next            = s_reg;
    s_next.match      = hit;
    s_next.resp_start = 1'b0;

    // Configuration writes; out-of-range station and wait values are dropped so the old value stays
    if (wr) begin
      unique case (paddr)
        ADDR_STATION: begin
          if (pwdata[31:0] >= STATION_MIN && pwdata[31:0] <= STATION_MAX) begin
            s_next.station = pwdata[5:0];
          end
        end
        ADDR_FORMAT:  s_next.fmt = pwdata[6:0];
        ADDR_TIMEOUT: begin
          s_next.to_time   = pwdata[7:0];
          s_next.to_action = pwdata[9:8];
        end
        ADDR_TXWAIT: begin
          if (pwdata[31:0] >= WAIT_MIN_MS && pwdata[31:0] <= WAIT_MAX_MS) begin
            s_next.wait_ms = pwdata[6:0];
          end
        end
        ADDR_STATUS:  s_next.status = s_reg.status & ~pwdata[1:0];
        ADDR_MASK:    s_next.mask = pwdata[1:0];
        default:      s_next.mask = s_reg.mask;
      endcase
    end
    // Set wins over a same-cycle clear
    s_next.status = s_next.status | ev;

    // Timeout supervision
    if (s_reg.to_time == 8'h0 || hit) begin
      s_next.to_sub   = 32'h0;
      s_next.to_tenth = 8'h0;
      s_next.timed_out = 1'b0;
    end else if (expire) begin
      s_next.timed_out = 1'b1;
    end else if (!s_reg.timed_out) begin
      if (s_reg.to_sub == TENTH_CYC - 1) begin
        s_next.to_sub   = 32'h0;
        s_next.to_tenth = s_reg.to_tenth + 8'h1;
      end else begin
        s_next.to_sub = s_reg.to_sub + 32'h1;
      end
    end

    // Turnaround delay before the reply
    unique case (s_reg.wstate)
      W_IDLE: begin
        if (hit) begin
          s_next.wstate = W_BUSY;
          s_next.wt_sub = 32'h0;
          s_next.wt_ms  = 7'h0;
        end
      end
      W_BUSY: begin
        if (wt_done) begin
          s_next.wstate     = W_IDLE;
          s_next.resp_start = 1'b1;
        end else if (s_reg.wt_sub == MS_CYC - 1) begin
          s_next.wt_sub = 32'h0;
          s_next.wt_ms  = s_reg.wt_ms + 7'h1;
        end else begin
          s_next.wt_sub = s_reg.wt_sub + 32'h1;
        end
      end
      default: s_next.wstate = W_IDLE;
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg         <= '0;
      s_reg.station <= STATION_RST;
      s_reg.wait_ms <= WAIT_RST;
      s_reg.wstate  <= W_IDLE;
    end else begin
      s_reg <= s_next;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Outputs

  assign frame_accept            = s_reg.match;
  assign resp_start              = s_reg.resp_start;
  assign char_fmt                = s_reg.fmt;
  assign link_timeout_indication = s_reg.timed_out;
  assign irq                     = |(s_reg.status & s_reg.mask);

  // Code 2 is not a documented rate; it falls back to 9600 as a safe default
  always_comb begin
    unique case (s_reg.fmt.baud_code)
      BAUD_CODE_4800:  baud_div = DIV_4800;
      BAUD_CODE_38400: baud_div = DIV_38400;
      default:         baud_div = DIV_9600;
    endcase
  end

  always_comb begin
    stop_cmd              = '0;
    stop_cmd.stop_decel1  = s_reg.timed_out & (s_reg.to_action == ACT_DECEL1);
    stop_cmd.stop_coast   = s_reg.timed_out & (s_reg.to_action == ACT_COAST);
    stop_cmd.stop_decel2  = s_reg.timed_out & (s_reg.to_action == ACT_DECEL2);
    stop_cmd.keep_running = s_reg.timed_out & (s_reg.to_action == ACT_KEEP);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence accepted_s;
    frame_valid && frame_station == {2'h0, s_reg.station};
  endsequence

  station_range_a: assert property (s_reg.station >= 6'h01 && s_reg.station <= 6'h20)
    else $error("station out of range");
  foreign_drop_a: assert property (frame_valid && frame_station != {2'h0, s_reg.station} |=> !frame_accept)
    else $error("foreign frame accepted");
  baud_map_a: assert property (s_reg.fmt.baud_code == 2'h3 |-> baud_div == DIV_38400)
    else $error("baud map wrong");
  fmt_follow_a: assert property (wr && paddr == ADDR_FORMAT |=> char_fmt == $past(pwdata[6:0]))
    else $error("format not stored");
  zero_off_a: assert property (s_reg.to_time == 8'h0 |=> !link_timeout_indication)
    else $error("timeout while disabled");
  restart_a: assert property (accepted_s |=> !link_timeout_indication && s_reg.to_sub == 32'h0)
    else $error("count not restarted");
  early_a: assert property (!s_reg.timed_out ##1 s_reg.timed_out |-> $past(s_reg.to_sub) == TENTH_CYC - 1)
    else $error("early expiry");
  decel1_a: assert property (link_timeout_indication && s_reg.to_action == ACT_DECEL1 |-> stop_cmd.stop_decel1)
    else $error("decel1 missing");
  actions_a: assert property (link_timeout_indication |-> $onehot(stop_cmd))
    else $error("stop action not unique");
  wait_gap_a: assert property (resp_start |-> s_reg.wstate == W_IDLE && $past(s_reg.wstate) == W_BUSY)
    else $error("reply without wait");

endmodule

`default_nettype wire

/* File: design/serial_cfg_pkg.sv */
package serial_cfg_pkg;
  // Clock and timing
  localparam int unsigned CLK_HZ         = 125_000_000;
  localparam int unsigned TENTH_SEC_MS   = 100;
  localparam int unsigned TENTH_CYCLES   = CLK_HZ / 1000 * TENTH_SEC_MS;
  localparam int unsigned MS_CYCLES      = CLK_HZ / 1000;
  localparam int unsigned WAIT_MIN_MS    = 5;
  localparam int unsigned WAIT_MAX_MS    = 65;
  localparam int unsigned STATION_MIN    = 1;
  localparam int unsigned STATION_MAX    = 32;

  // Bit period in clock cycles, rounded to nearest
  localparam int unsigned BAUD_4800      = 4800;
  localparam int unsigned BAUD_9600      = 9600;
  localparam int unsigned BAUD_38400     = 38400;
  localparam logic [15:0] DIV_4800       = 16'((CLK_HZ + BAUD_4800 / 2) / BAUD_4800);
  localparam logic [15:0] DIV_9600       = 16'((CLK_HZ + BAUD_9600 / 2) / BAUD_9600);
  localparam logic [15:0] DIV_38400      = 16'((CLK_HZ + BAUD_38400 / 2) / BAUD_38400);

  // Register byte addresses
  localparam logic [7:0] ADDR_STATION    = 8'h00;
  localparam logic [7:0] ADDR_FORMAT     = 8'h04;
  localparam logic [7:0] ADDR_TIMEOUT    = 8'h08;
  localparam logic [7:0] ADDR_TXWAIT     = 8'h0c;
  localparam logic [7:0] ADDR_STATUS     = 8'h10;
  localparam logic [7:0] ADDR_MASK       = 8'h14;
  localparam logic [7:0] ADDR_STATE      = 8'h18;

  // Reset values
  localparam logic [5:0] STATION_RST     = 6'h01;
  localparam logic [6:0] WAIT_RST        = 7'h05;

  // Status bit positions
  localparam int unsigned ST_TIMEOUT     = 0;
  localparam int unsigned ST_FRAME       = 1;

  // Codes
  localparam logic [1:0] BAUD_CODE_4800  = 2'h0;
  localparam logic [1:0] BAUD_CODE_9600  = 2'h1;
  localparam logic [1:0] BAUD_CODE_38400 = 2'h3;
  localparam logic [1:0] ACT_DECEL1      = 2'h0;
  localparam logic [1:0] ACT_COAST       = 2'h1;
  localparam logic [1:0] ACT_DECEL2      = 2'h2;
  localparam logic [1:0] ACT_KEEP        = 2'h3;

  typedef enum logic [1:0] {
    W_IDLE = 2'b01,
    W_BUSY = 2'b10
  } wait_state_t;

  typedef struct packed {
    logic       framing_ascii;
    logic [1:0] baud_code;
    logic       stop_two;
    logic [1:0] parity;
    logic       data_seven;
  } char_fmt_t;

  typedef struct packed {
    logic stop_decel1;
    logic stop_coast;
    logic stop_decel2;
    logic keep_running;
  } stop_cmd_t;

  typedef struct packed {
    logic [5:0]  station;
    char_fmt_t   fmt;
    logic [7:0]  to_time;
    logic [1:0]  to_action;
    logic [6:0]  wait_ms;
    logic [1:0]  status;
    logic [1:0]  mask;
    logic [31:0] to_sub;
    logic [7:0]  to_tenth;
    logic        timed_out;
    wait_state_t wstate;
    logic [31:0] wt_sub;
    logic [6:0]  wt_ms;
    logic        resp_start;
    logic        match;
  } state_t;
endpackage

/* File: tb/drive_serial_comm_config_tb.sv */
`timescale 1ns/100ps
`default_nettype none
module drive_serial_comm_config_tb;
  import serial_cfg_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, fv, fa, rs, ind, irq;
  logic [7:0]  paddr, fs;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] bdiv;
  char_fmt_t   cfmt;
  stop_cmd_t   scmd;
  logic        e;
  int          err_total, cmp_count, n, k;
  always #4 pclk = ~pclk;
  drive_serial_comm_config #(.TENTH_CYC(10), .MS_CYC(4)) drive_serial_comm_config_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .frame_valid(fv), .frame_station(fs), .frame_accept(fa), .resp_start(rs),
    .char_fmt(cfmt), .baud_div(bdiv), .link_timeout_indication(ind), .stop_cmd(scmd), .irq(irq));
  master_model master_model_inst (.pclk(pclk), .resp_start(rs), .frame_valid(fv), .frame_station(fs));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    e  = pslverr;
    psel <= 1'b0; penable <= 1'b0;
  endtask
  task automatic t_reset_map;
    apb(0, ADDR_STATION, 0); chk(rd, 32'h1);
    apb(0, ADDR_TXWAIT, 0);  chk(rd, 32'h5);
    chk(bdiv, DIV_4800);
    apb(0, 8'h1c, 0); chk(e, 1'b1);
    chk(rd, 32'h0);
  endtask
  task automatic t_station;
    apb(1, ADDR_STATION, 0);  apb(1, ADDR_STATION, 33); apb(0, ADDR_STATION, 0); chk(rd, 32'h1);
    apb(1, ADDR_STATION, 32); apb(0, ADDR_STATION, 0);  chk(rd, 32'd32);
    master_model_inst.send(8'd31); #1 chk(fa, 0);
    master_model_inst.send(rd[7:0]); #1 chk(fa, 1);
  endtask
  task automatic t_format;
    logic [6:0] v [3] = '{7'h00, 7'h5c, 7'h33};
    logic [15:0] d [3] = '{DIV_4800, DIV_9600, DIV_38400};
    for (k = 0; k < 3; k++) begin
      apb(1, ADDR_FORMAT, 32'(v[k])); #1;
      chk(32'(cfmt), 32'(v[k]));
      chk(bdiv, d[k]);
    end
  endtask
  task automatic t_timeout;
    apb(1, ADDR_MASK, 32'h0);
    for (k = 0; k < 4; k++) begin
      apb(1, ADDR_TIMEOUT, {22'h0, 2'(k), 8'h02});
      master_model_inst.send(8'd32);
      repeat (15) @(posedge pclk); #1 chk(ind, 0);
      master_model_inst.send(8'd32);
      repeat (15) @(posedge pclk); #1 chk(ind, 0);
      repeat (10) @(posedge pclk); #1 chk(ind, 1);
      chk(scmd, 4'h8 >> k);
    end
    apb(0, ADDR_STATUS, 0); chk(rd, 32'h3);
    apb(0, ADDR_STATE, 0);  chk(rd, 32'h1);
    // Status is sticky; the masked view alone drives the line
    chk(irq, 0);
    apb(1, ADDR_MASK, 32'h1); #1 chk(irq, 1);
    apb(1, ADDR_STATUS, 32'h3); #1 chk(irq, 0);
    // Indication drops one cycle after the zero time is stored
    apb(1, ADDR_TIMEOUT, 0);
    @(posedge pclk);
    #1 chk({ind, scmd}, 0);
    master_model_inst.send(8'd32);
    repeat (60) @(posedge pclk); #1 chk({ind, scmd}, 0);
  endtask
  task automatic t_reply;
    int w [2] = '{5, 65};
    apb(1, ADDR_TXWAIT, 4); apb(1, ADDR_TXWAIT, 66); apb(0, ADDR_TXWAIT, 0); chk(rd, 32'h5);
    for (k = 0; k < 2; k++) begin
      apb(1, ADDR_TXWAIT, w[k]);
      n = master_model_inst.resp_seen;
      master_model_inst.send(8'd32);
      e = 1'b0;
      for (int c = 1; c < 400 && !e; c++) begin
        @(posedge pclk);
        if (rs === 1'b1) begin
          e = 1'b1;
          chk(c >= w[k] * 4 && c <= w[k] * 4 + 2, 1);
        end
      end
      chk(e, 1);
      @(posedge pclk); #1 chk(master_model_inst.resp_seen, n + 1);
    end
  endtask
  task automatic t_reset_mid;
    apb(0, ADDR_FORMAT, 0);
    apb(1, ADDR_FORMAT, rd | 32'h40); #1 chk(32'(cfmt), 32'h73);
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    #1 chk({cfmt, bdiv, ind, irq, fa, rs}, {7'h00, DIV_4800, 4'h0});
    @(posedge pclk);
    presetn <= 1'b1;
    apb(0, ADDR_STATION, 0); chk(rd, 32'h1);
    apb(0, ADDR_FORMAT, 0);  chk(rd, 32'h0);
  endtask
  task automatic give_verdict;
    $display("compares=%0d mismatches=%0d", cmp_count, err_total);
    if (err_total == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  initial begin
    repeat (20000) @(posedge pclk);
    err_total++;
    give_verdict();
  end
  initial begin
    pclk = 1'b0; presetn = 1'b0; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 8'h00; pwdata = 32'h0; err_total = 0; cmp_count = 0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset_map();
    t_station();
    t_format();
    t_timeout();
    t_reply();
    t_reset_mid();
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: tb/master_model.sv */
`timescale 1ns/100ps
`default_nettype none
module master_model (
  input  wire logic       pclk,
  input  wire logic       resp_start,
  output logic            frame_valid,
  output logic [7:0]      frame_station
);
  int resp_seen = 0;
  initial begin
    frame_valid   = 1'b0;
    frame_station = 8'h00;
  end
  always @(posedge pclk) begin
    if (resp_start === 1'b1) begin
      resp_seen <= resp_seen + 1;
    end
  end
  // Framing and rate are agreed out of band, never changed mid-frame
  task automatic send(input logic [7:0] st);
    @(posedge pclk);
    frame_valid   <= 1'b1;
    frame_station <= st;
    @(posedge pclk);
    frame_valid   <= 1'b0;
    // Inverted idle value so a stale station never looks valid
    frame_station <= ~st;
  endtask
endmodule
`default_nettype wire
